/* File: bench/cmpw_panel_writer_checker.sv */
// port assertions for the panel writer
`timescale 1ns/1ns
`default_nettype none
module cmpw_panel_writer_checker
    import cmpw_pkg::*;
(
    // system
    input wire logic clk,
    input wire logic rst_b,
    // link
    input wire logic sclk,
    input wire logic sdataIn,
    input wire logic sdataOut,
    input wire logic sdataOe,
    // status and memory port
    input wire logic cmdFifoFull,
    input wire cmpw_prog_t prog,
    input wire logic [PANEL_COUNT*BUF_BYTES*8-1:0] progData,
    input wire logic multiPanelMode,
    input wire logic [21:0] tablePointer
);
    // ------------------------------------------------
    // assertions
    // ------------------------------------------------
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    a_start_on_high: assert property ($rose(prog.active) |-> sclk)
        else $error("programming began with link clock low");
    a_held_while_high: assert property (sclk [*4] ##0 prog.active |=> prog.active)
        else $error("programming stopped while link clock high");
    a_end_on_fall: assert property ($fell(sclk) && prog.active |-> ##[1:6] !prog.active)
        else $error("programming ran on after link clock fell");
    a_all_panels: assert property (
        $rose(prog.active) && multiPanelMode |-> prog.panelMask inside {4'h0, 4'hf})
        else $error("multi panel start without all panels");
    a_start_offset: assert property (
        $rose(prog.active) |-> prog.rowOffset == tablePointer[12:3])
        else $error("row offset differs from pointer");
    a_prog_steady: assert property (prog.active [*2] |-> $stable(prog))
        else $error("programming fields moved mid pulse");
    a_buffer_quiet: assert property (prog.active [*2] |-> $stable(progData))
        else $error("buffer changed during programming");
    a_mode_at_ctl: assert property (
        $rose(multiPanelMode) |-> tablePointer == MODE_CTL_ADDR)
        else $error("mode set away from control location");
endmodule // cmpw_panel_writer_checker

bind cmpw_panel_writer cmpw_panel_writer_checker chk (.clk(clk), .rst_b(rst_b), .sclk(sclk),
    .sdataIn(sdataIn), .sdataOut(sdataOut), .sdataOe(sdataOe), .cmdFifoFull(cmdFifoFull),
    .prog(prog), .progData(progData), .multiPanelMode(multiPanelMode),
    .tablePointer(tablePointer));
`default_nettype wire

/* File: bench/cmpw_panel_writer_tb.sv */
// self checking bench for the panel writer
`timescale 1ns/1ns
`default_nettype none
module cmpw_panel_writer_tb
    import cmpw_pkg::*;
;
    // ------------------------------------------------
    // signals and instances
    // ------------------------------------------------
    logic clk;
    logic rst_b;
    logic sclk;
    logic sdataIn;
    logic sdataOut;
    logic sdataOe;
    logic cmdFifoFull;
    cmpw_prog_t prog;
    logic [PANEL_COUNT*BUF_BYTES*8-1:0] progData;
    logic multiPanelMode;
    logic [21:0] tablePointer;
    int miscompares = 0;
    int testsRun = 0;

    cmpw_programmer pgm (.sclk(sclk), .sdataIn(sdataIn));
    cmpw_panel_writer DUT (.clk(clk), .rst_b(rst_b), .sclk(sclk), .sdataIn(sdataIn),
        .sdataOut(sdataOut), .sdataOe(sdataOe), .cmdFifoFull(cmdFifoFull), .prog(prog),
        .progData(progData), .multiPanelMode(multiPanelMode), .tablePointer(tablePointer));

    // ------------------------------------------------
    // helpers
    // ------------------------------------------------
    task automatic checkVal(input string what, input logic [31:0] exp, input logic [31:0] got);
        testsRun++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic word(input logic [3:0] c, input logic [15:0] p);
        pgm.sendWord(c, p, 0, 0);
        settle(8);
    endtask

    task automatic setPtr(input logic [21:0] a);
        word(CMD_CORE, {OP_LOAD_LITERAL, 2'h0, a[21:16]});
        word(CMD_CORE, {OP_STORE_FILE, 1'b0, FILE_PTR_UPPER});
        word(CMD_CORE, {OP_LOAD_LITERAL, a[15:8]});
        word(CMD_CORE, {OP_STORE_FILE, 1'b0, FILE_PTR_HIGH});
        word(CMD_CORE, {OP_LOAD_LITERAL, a[7:0]});
        word(CMD_CORE, {OP_STORE_FILE, 1'b0, FILE_PTR_LOW});
        checkVal("tablePointer", 32'(a), 32'(tablePointer));
    endtask

    task automatic waitActive(input logic v);
        int n;
        n = 0;
        while (prog.active !== v && n < 600) begin
            settle(1);
            n++;
        end
        checkVal("progActive", 32'(v), 32'(prog.active));
    endtask

    function automatic logic [7:0] byteVal(input int p, input int b, input int l);
        return 8'(l * 64 + p * 16 + b + 1);
    endfunction

    // ------------------------------------------------
    // scenarios
    // ------------------------------------------------
    task automatic testReset();
        checkVal("prog", 32'h0, 32'(prog));
        checkVal("mode", 32'h0, 32'(multiPanelMode));
        checkVal("pointer", 32'h0, 32'(tablePointer));
        checkVal("sdataOe", 32'h0, 32'(sdataOe));
        checkVal("sdataOut", 32'h0, 32'(sdataOut));
        checkVal("fifoFull", 32'h0, 32'(cmdFifoFull));
        for (int i = 0; i < PANEL_COUNT * BUF_BYTES; i++)
            checkVal("resetByte", 32'hff, 32'(progData[i*8 +: 8]));
    endtask

    task automatic testMode();
        setPtr(MODE_CTL_ADDR);
        word(CMD_WRITE, 16'h0040);
        checkVal("modeRefused", 32'h0, 32'(multiPanelMode));
        word(CMD_CORE, 16'h8ea6);
        word(CMD_CORE, 16'h8ca6);
        word(CMD_CORE, 16'h86a6);
        word(CMD_CORE, 16'h84a6);
        setPtr(MODE_CTL_ADDR);
        word(CMD_WRITE, 16'h0040);
        checkVal("modeSet", 32'h1, 32'(multiPanelMode));
        checkVal("noStep", 32'(MODE_CTL_ADDR), 32'(tablePointer));
    endtask

    task automatic startAndHold(input int l, input logic [15:0] d, input logic [3:0] m);
        pgm.sendWord(CMD_WRITE_START, d, 0, 0);
        fork
            pgm.sendWord(CMD_CORE, 16'h0000, 3000, 300);
            begin
                waitActive(1'b1);
                checkVal("panelMask", 32'(m), 32'(prog.panelMask));
                checkVal("rowOffset", 32'(l), 32'(prog.rowOffset));
                checkVal("sclkHigh", 32'h1, 32'(sclk));
                waitActive(1'b0);
                checkVal("sclkLow", 32'h0, 32'(sclk));
            end
        join
        settle(8);
    endtask

    task automatic testWrite(input int l);
        logic [21:0] base;
        logic [3:0] c;
        logic [15:0] d;
        word(CMD_CORE, 16'h8ea6);
        word(CMD_CORE, 16'h9ca6);
        for (int p = 0; p < PANEL_COUNT; p++) begin
            base = 22'(p * 'h2000 + 8 * l);
            setPtr(base);
            for (int k = 0; k < 4; k++) begin
                c = (k < 3) ? CMD_WRITE_INC : CMD_WRITE;
                d = {byteVal(p, 2 * k + 1, l), byteVal(p, 2 * k, l)};
                if (k == 3 && p == PANEL_COUNT - 1)
                    startAndHold(l, d, 4'hf);
                else
                    word(c, d);
            end
            checkVal("pointerStep", 32'(base + 22'h6), 32'(tablePointer));
        end
        for (int p = 0; p < PANEL_COUNT; p++)
            for (int b = 0; b < BUF_BYTES; b++)
                checkVal("bufByte", 32'(byteVal(p, b, l)), 32'(progData[64*p+8*b+:8]));
    endtask

    task automatic testSingle();
        logic [15:0] d;
        word(CMD_CORE, 16'h8ca6);
        setPtr(MODE_CTL_ADDR);
        word(CMD_WRITE, 16'h0000);
        checkVal("modeOff", 32'h0, 32'(multiPanelMode));
        word(CMD_CORE, 16'h9ca6);
        setPtr(22'h004000);
        for (int k = 0; k < 4; k++) begin
            d = {byteVal(2, 2 * k + 1, 2), byteVal(2, 2 * k, 2)};
            if (k < 3)
                word(CMD_WRITE_INC, d);
            else
                startAndHold(0, d, 4'h4);
        end
        for (int b = 0; b < BUF_BYTES; b++) begin
            checkVal("singleByte", 32'(byteVal(2, b, 2)), 32'(progData[128+8*b +: 8]));
            checkVal("otherByte", 32'(byteVal(1, b, 1)), 32'(progData[64+8*b +: 8]));
        end
    endtask

    // ------------------------------------------------
    // run control
    // ------------------------------------------------
    task automatic endOfTest();
        $display("comparisons %0d mismatches %0d", testsRun, miscompares);
        if (miscompares == 0 && testsRun > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        rst_b = 1'b0;
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        settle(1);
        testReset();
        testMode();
        testWrite(0);
        testWrite(1);
        testSingle();
        endOfTest();
    end

    initial begin
        #400_000;
        miscompares++;
        $display("BAD watchdog expected done seen hang");
        endOfTest();
    end
endmodule // cmpw_panel_writer_tb
`default_nettype wire

/* File: bench/cmpw_programmer.sv */
// serial programmer model driving the two wire link
`timescale 1ns/1ns
`default_nettype none
module cmpw_programmer
    import cmpw_pkg::*;
#(
    parameter int HALF_NS = 24
) (
    // link pins
    output logic sclk,
    output logic sdataIn
);
    // ------------------------------------------------
    // link clock idles low between frames
    // ------------------------------------------------
    initial begin
        sclk = 1'b0;
        sdataIn = 1'b0;
    end

    // one bit: data set on the rise, sampled on the fall
    task automatic sendBit(input logic b, input int highNs);
        sclk = 1'b1;
        sdataIn = b;
        #(highNs);
        sclk = 1'b0;
        #(HALF_NS);
    endtask

    // command then payload, lsb first; optional hold on the 4th clock
    task automatic sendWord(input logic [3:0] c, input logic [15:0] p, input int holdNs,
        input int lowNs);
        logic [19:0] f;
        f = {p, c};
        for (int i = 0; i < FRAME_BITS; i++) begin
            if (i == 3 && holdNs > 0) begin
                sendBit(f[i], holdNs);
                #(lowNs);
            end else begin
                sendBit(f[i], HALF_NS);
            end
        end
        sdataIn = ~sdataIn;
        #(HALF_NS);
    endtask
endmodule // cmpw_programmer
`default_nettype wire

/* File: rtl/cmpw_panel_writer.sv */
// code memory panel writer behind the two wire programming link
`timescale 1ns/1ns
`default_nettype none
module cmpw_panel_writer
    import cmpw_pkg::*;
(
    // system
    input wire logic clk,
    input wire logic rst_b,
    // serial link
    input wire logic sclk,
    input wire logic sdataIn,
    output logic sdataOut,
    output logic sdataOe,
    // flow status
    output logic cmdFifoFull,
    // code memory port
    output cmpw_prog_t prog,
    output logic [PANEL_COUNT*BUF_BYTES*8-1:0] progData,
    // state
    output logic multiPanelMode,
    output logic [21:0] tablePointer
);

    // -------------------------------------------------------------
    // link domain
    // -------------------------------------------------------------
    logic [4:0] bitCnt_reg;
    logic [FRAME_BITS-1:0] shift_reg;
    logic [FRAME_BITS-1:0] frameFull;
    cmpw_word_t linkWord_reg;
    logic wordTgl_reg;
    logic armed_reg;
    logic holdTgl_reg;

    assign frameFull = {sdataIn, shift_reg[FRAME_BITS-1:1]};
    assign sdataOut = 1'b0;
    assign sdataOe = 1'b0;

    always_ff @(negedge sclk or negedge rst_b) begin
        if (!rst_b) begin
            bitCnt_reg <= BIT_CNT_RST;
        end else if (bitCnt_reg == FRAME_LAST) begin
            bitCnt_reg <= BIT_CNT_RST;
        end else begin
            bitCnt_reg <= bitCnt_reg + 5'h01;
        end
    end

    always_ff @(negedge sclk or negedge rst_b) begin
        if (!rst_b) begin
            shift_reg <= '0;
        end else begin
            shift_reg <= frameFull;
        end
    end

    always_ff @(negedge sclk or negedge rst_b) begin
        if (!rst_b) begin
            linkWord_reg <= '0;
            wordTgl_reg <= 1'b0;
        end else if (bitCnt_reg == FRAME_LAST) begin
            linkWord_reg.cmd <= frameFull[CMD_BITS-1:0];
            linkWord_reg.payload <= frameFull[FRAME_BITS-1:CMD_BITS];
            wordTgl_reg <= ~wordTgl_reg;
        end
    end

    // third clock of the no-op after a start marks the hold
    always_ff @(negedge sclk or negedge rst_b) begin
        if (!rst_b) begin
            armed_reg <= 1'b0;
            holdTgl_reg <= 1'b0;
        end else if (bitCnt_reg == FRAME_LAST) begin
            armed_reg <= (frameFull[CMD_BITS-1:0] == CMD_WRITE_START);
        end else if (armed_reg && bitCnt_reg == HOLD_BIT_IDX) begin
            armed_reg <= 1'b0;
            holdTgl_reg <= ~holdTgl_reg;
        end
    end

    // -------------------------------------------------------------
    // crossing into the system clock
    // -------------------------------------------------------------
    logic [1:0] wordSync_reg;
    logic [1:0] holdSync_reg;
    logic [1:0] sclkSync_reg;
    logic wordPrev_reg;
    logic holdPrev_reg;
    logic sclkPrev_reg;
    logic wordEvent;
    logic holdEvent;
    logic sclkRise;
    logic sclkFall;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wordSync_reg <= 2'h0;
            holdSync_reg <= 2'h0;
            sclkSync_reg <= 2'h0;
            wordPrev_reg <= 1'b0;
            holdPrev_reg <= 1'b0;
            sclkPrev_reg <= 1'b0;
        end else begin
            wordSync_reg <= {wordSync_reg[0], wordTgl_reg};
            holdSync_reg <= {holdSync_reg[0], holdTgl_reg};
            sclkSync_reg <= {sclkSync_reg[0], sclk};
            wordPrev_reg <= wordSync_reg[1];
            holdPrev_reg <= holdSync_reg[1];
            sclkPrev_reg <= sclkSync_reg[1];
        end
    end

    assign wordEvent = wordSync_reg[1] ^ wordPrev_reg;
    assign holdEvent = holdSync_reg[1] ^ holdPrev_reg;
    assign sclkRise = sclkSync_reg[1] && !sclkPrev_reg;
    assign sclkFall = !sclkSync_reg[1] && sclkPrev_reg;

    // -------------------------------------------------------------
    // command queue
    // -------------------------------------------------------------
    logic fifoInReady;
    logic fifoOutValid;
    logic fifoOutReady;
    cmpw_word_t cmdWord;
    cmpw_state_t state_reg;

    cmpw_word_fifo #(
        .WIDTH($bits(cmpw_word_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_cmd_fifo (
        .clk(clk),
        .rst_b(rst_b),
        .inValid(wordEvent),
        .inReady(fifoInReady),
        .inData(linkWord_reg),
        .outValid(fifoOutValid),
        .outReady(fifoOutReady),
        .outData(cmdWord)
    );

    assign cmdFifoFull = !fifoInReady;
    assign fifoOutReady = (state_reg == ST_EXEC);

    // -------------------------------------------------------------
    // command decode
    // -------------------------------------------------------------
    logic [7:0] wreg_reg;
    logic [7:0] memCtl_reg;
    logic [7:0] modeCtl_reg;
    logic [21:0] tablePointer_reg;
    logic take;
    logic isCore;
    logic isTblWr;
    logic fileWr;
    logic [7:0] fileAddr;
    logic [7:0] fileOld;
    logic [7:0] fileNew;
    logic bufWr;
    logic modeWr;

    assign take = fifoOutValid && fifoOutReady;
    assign isCore = take && cmdWord.cmd == CMD_CORE;
    assign isTblWr = take && (cmdWord.cmd == CMD_WRITE ||
        cmdWord.cmd == CMD_WRITE_INC || cmdWord.cmd == CMD_WRITE_START);
    assign fileAddr = cmdWord.payload[7:0];
    assign bufWr = isTblWr && memCtl_reg[PGM_SEL_BIT] && !memCtl_reg[CFG_SEL_BIT];
    assign modeWr = isTblWr && memCtl_reg[CFG_SEL_BIT] &&
        tablePointer_reg == MODE_CTL_ADDR;

    always_comb begin
        unique case (fileAddr)
            FILE_PTR_LOW: fileOld = tablePointer_reg[7:0];
            FILE_PTR_HIGH: fileOld = tablePointer_reg[15:8];
            FILE_PTR_UPPER: fileOld = {2'h0, tablePointer_reg[21:16]};
            FILE_MEM_CTL: fileOld = memCtl_reg;
            default: fileOld = 8'h00;
        endcase
    end

    // core instruction effect on a file register
    always_comb begin
        fileWr = 1'b0;
        fileNew = fileOld;
        if (isCore) begin
            if (cmdWord.payload[15:9] == OP_STORE_FILE) begin
                fileWr = 1'b1;
                fileNew = wreg_reg;
            end else if (cmdWord.payload[15:9] == OP_CLEAR_FILE) begin
                fileWr = 1'b1;
                fileNew = 8'h00;
            end else if (cmdWord.payload[15:12] == OP_BIT_SET) begin
                fileWr = 1'b1;
                fileNew[cmdWord.payload[11:9]] = 1'b1;
            end else if (cmdWord.payload[15:12] == OP_BIT_CLEAR) begin
                fileWr = 1'b1;
                fileNew[cmdWord.payload[11:9]] = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wreg_reg <= WREG_RST;
        end else if (isCore && cmdWord.payload[15:8] == OP_LOAD_LITERAL) begin
            wreg_reg <= cmdWord.payload[7:0];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            memCtl_reg <= MEM_CTL_RST;
        end else if (fileWr && fileAddr == FILE_MEM_CTL) begin
            memCtl_reg <= fileNew;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            modeCtl_reg <= MODE_CTL_RST;
        end else if (modeWr) begin
            modeCtl_reg <= cmdWord.payload[7:0];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tablePointer_reg <= PTR_RST;
        end else if (fileWr && fileAddr == FILE_PTR_LOW) begin
            tablePointer_reg[7:0] <= fileNew;
        end else if (fileWr && fileAddr == FILE_PTR_HIGH) begin
            tablePointer_reg[15:8] <= fileNew;
        end else if (fileWr && fileAddr == FILE_PTR_UPPER) begin
            tablePointer_reg[21:16] <= fileNew[5:0];
        end else if (isTblWr && cmdWord.cmd == CMD_WRITE_INC) begin
            tablePointer_reg <= tablePointer_reg + PTR_STEP;
        end
    end

    assign tablePointer = tablePointer_reg;
    assign multiPanelMode = modeCtl_reg[MULTI_PANEL_BIT];

    // -------------------------------------------------------------
    // panel write buffers
    // -------------------------------------------------------------
    logic [1:0] wrPanel;
    logic [1:0] wrWordIdx;

    assign wrPanel = tablePointer_reg[PANEL_LSB+1:PANEL_LSB];
    assign wrWordIdx = tablePointer_reg[2:1];

    for (genvar p = 0; p < PANEL_COUNT; p++) begin : g_panel
        logic [7:0] buf_reg [BUF_BYTES];

        always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
                for (int b = 0; b < BUF_BYTES; b++) begin
                    buf_reg[b] <= 8'hff;
                end
            end else if (bufWr && wrPanel == 2'(p)) begin
                buf_reg[{wrWordIdx, 1'b0}] <= cmdWord.payload[7:0];
                buf_reg[{wrWordIdx, 1'b1}] <= cmdWord.payload[15:8];
            end
        end

        for (genvar b = 0; b < BUF_BYTES; b++) begin : g_byte
            assign progData[(p*BUF_BYTES+b)*8 +: 8] = buf_reg[b];
        end
    end

    // -------------------------------------------------------------
    // programming sequence
    // -------------------------------------------------------------
    logic holdSeen_reg;
    logic startProg;
    logic [PANEL_COUNT-1:0] maskNext;

    assign startProg = (state_reg == ST_WAIT_HOLD) && holdSeen_reg && sclkRise;

    // hold mark that arrives in the clearing cycle survives
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            holdSeen_reg <= 1'b0;
        end else if (holdEvent) begin
            holdSeen_reg <= 1'b1;
        end else if (startProg) begin
            holdSeen_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= ST_EXEC;
        end else begin
            unique case (state_reg)
                ST_EXEC: begin
                    if (isTblWr && cmdWord.cmd == CMD_WRITE_START) begin
                        state_reg <= ST_WAIT_HOLD;
                    end
                end
                ST_WAIT_HOLD: begin
                    if (startProg) begin
                        state_reg <= ST_PROGRAM;
                    end
                end
                ST_PROGRAM: begin
                    if (sclkFall) begin
                        state_reg <= ST_EXEC;
                    end
                end
            endcase
        end
    end

    always_comb begin
        maskNext = '0;
        if (multiPanelMode) begin
            maskNext = '1;
        end else begin
            maskNext[wrPanel] = 1'b1;
        end
        if (!memCtl_reg[WRITE_ENABLE_BIT_BIT] || !memCtl_reg[PGM_SEL_BIT] ||
            memCtl_reg[CFG_SEL_BIT]) begin
            maskNext = '0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prog <= '0;
        end else if (startProg) begin
            prog.active <= 1'b1;
            prog.panelMask <= maskNext;
            prog.rowOffset <= tablePointer_reg[PANEL_LSB-1:3];
        end else if (state_reg == ST_PROGRAM && sclkFall) begin
            prog.active <= 1'b0;
            prog.panelMask <= '0;
        end
    end

endmodule // cmpw_panel_writer
`default_nettype wire

/* File: rtl/cmpw_pkg.sv */
// constants and types shared by the code memory panel writer
package cmpw_pkg;

    // -------------------------------------------------------------
    // serial frame
    // -------------------------------------------------------------
    localparam int CMD_BITS = 4;
    localparam int PAYLOAD_BITS = 16;
    localparam int FRAME_BITS = CMD_BITS + PAYLOAD_BITS;
    localparam logic [4:0] FRAME_LAST = 5'h13;
    localparam logic [4:0] HOLD_BIT_IDX = 5'h02;
    localparam logic [4:0] BIT_CNT_RST = 5'h00;

    // -------------------------------------------------------------
    // four bit commands and the pointer step
    // -------------------------------------------------------------
    localparam logic [3:0] CMD_CORE = 4'h0;
    localparam logic [3:0] CMD_WRITE = 4'hc;
    localparam logic [3:0] CMD_WRITE_INC = 4'hd;
    localparam logic [3:0] CMD_WRITE_START = 4'hf;
    localparam logic [21:0] PTR_STEP = 22'h000002;

    // -------------------------------------------------------------
    // core instruction decode
    // -------------------------------------------------------------
    localparam logic [7:0] OP_LOAD_LITERAL = 8'h0e;
    localparam logic [6:0] OP_STORE_FILE = 7'h37;
    localparam logic [6:0] OP_CLEAR_FILE = 7'h35;
    localparam logic [3:0] OP_BIT_SET = 4'h8;
    localparam logic [3:0] OP_BIT_CLEAR = 4'h9;
    localparam logic [7:0] FILE_PTR_LOW = 8'hf6;
    localparam logic [7:0] FILE_PTR_HIGH = 8'hf7;
    localparam logic [7:0] FILE_PTR_UPPER = 8'hf8;
    localparam logic [7:0] FILE_MEM_CTL = 8'ha6;

    // -------------------------------------------------------------
    // control bits, addresses, reset values
    // -------------------------------------------------------------
    localparam int PGM_SEL_BIT = 7;
    localparam int CFG_SEL_BIT = 6;
    localparam int WRITE_ENABLE_BIT_BIT = 2;
    localparam int MULTI_PANEL_BIT = 6;
    localparam logic [21:0] MODE_CTL_ADDR = 22'h3c0006;
    localparam logic [7:0] MODE_CTL_RST = 8'h00;
    localparam logic [7:0] MEM_CTL_RST = 8'h00;
    localparam logic [7:0] WREG_RST = 8'h00;
    localparam logic [21:0] PTR_RST = 22'h000000;

    // -------------------------------------------------------------
    // panels and buffers
    // -------------------------------------------------------------
    localparam int PANEL_COUNT = 4;
    localparam int BUF_BYTES = 8;
    localparam int PANEL_LSB = 13;
    localparam int FIFO_DEPTH = 16;

    typedef struct packed {
        logic [3:0] cmd;
        logic [15:0] payload;
    } cmpw_word_t;

    typedef struct packed {
        logic active;
        logic [PANEL_COUNT-1:0] panelMask;
        logic [9:0] rowOffset;
    } cmpw_prog_t;

    typedef enum logic [1:0] {
        ST_EXEC,
        ST_WAIT_HOLD,
        ST_PROGRAM
    } cmpw_state_t;

endpackage : cmpw_pkg

/* File: rtl/cmpw_word_fifo.sv */
// synchronous word fifo with valid and ready on both sides
`timescale 1ns/1ns
`default_nettype none
module cmpw_word_fifo #(
    parameter int WIDTH = 20,
    parameter int DEPTH = 16
) (
    // system
    input wire logic clk,
    input wire logic rst_b,
    // fill side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // drain side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_reg;
    logic [AW-1:0] rdPtr_reg;
    logic [AW:0] count_reg;
    logic push;
    logic pop;

    assign inReady = (count_reg != (AW+1)'(DEPTH));
    assign outValid = (count_reg != '0);
    assign push = inValid && inReady;
    assign pop = outValid && outReady;
    assign outData = mem[rdPtr_reg];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wrPtr_reg] <= inData;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wrPtr_reg <= wrPtr_reg + 1'b1;
            end
            if (pop) begin
                rdPtr_reg <= rdPtr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule // cmpw_word_fifo
`default_nettype wire
